// File: rtl/tmrx_clock_fabric.sv
// How it works
// - rgb, 444 and 422 pixels map identically to stream and native outputs, via a fifo.
// - horizontal total not divisible by four needs two pixels per cycle, flagged here.
// - four pixels per cycle recommended for high resolutions; slower video clock.
// - five independent clocks: control, stream video, audio, link, native video.
// - pixel clock equals data clock scaled by eight over bits per component.
// - phy delivers link words on link clock; core splits video, audio, aux.
// - stream mode bridges native video to axi4-stream in stream clock domain.
// - native mode outputs video straight on native video clock, no bridge.
// - control, stream and audio each have an active-low reset in own domain.
// - native mode drives a video reset output for downstream logic.
// - control reset clears the whole device, data path included.
`timescale 1ns/10ps

// async assert, sync release; first stage feeds only the second
module tmrx_rst_sync (
    input wire logic clk,
    input wire logic arst_n,
    output logic rst_n_out
);
    logic meta;

    // constant shifted in, so release lands on a clean edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= tmrx_pkg::RST_ASSERTED;
            rst_n_out <= tmrx_pkg::RST_ASSERTED;
        end else begin
            meta <= 1'h1;
            rst_n_out <= meta;
        end
    end
endmodule

// dual-clock fifo, first word falls through on the read side
module tmrx_afifo #(
    parameter int W = 8,
    parameter int AW = 4
) (
    // write side
    input wire logic wr_clk,
    input wire logic wr_rst_n,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    output logic full,
    // read side
    input wire logic rd_clk,
    input wire logic rd_rst_n,
    input wire logic rd_en,
    output logic [W-1:0] rd_data,
    output logic empty
);
    logic [W-1:0] mem [2**AW];
    logic [AW:0] wbin, wgray, rbin, rgray, wq1, wq2, rq1, rq2;
    logic [AW:0] next_wbin, next_wgray, next_rbin, next_rgray;
    logic next_full, next_empty;

    // pointer arithmetic; full compares against the synchronised read gray
    always_comb begin
        next_wbin = wbin + {{AW{1'h0}}, wr_en & ~full};
        next_wgray = (next_wbin >> 1) ^ next_wbin;
        next_full = (next_wgray == {~wq2[AW:AW-1], wq2[AW-2:0]});
        next_rbin = rbin + {{AW{1'h0}}, rd_en & ~empty};
        next_rgray = (next_rbin >> 1) ^ next_rbin;
        next_empty = (next_rgray == rq2);
    end

    // write domain; only gray codes cross, one bit changes per step
    always_ff @(posedge wr_clk or negedge wr_rst_n) begin
        if (!wr_rst_n) begin
            wbin <= '0;
            wgray <= '0;
            full <= 1'h0;
            wq1 <= '0;
            wq2 <= '0;
        end else begin
            wbin <= next_wbin;
            wgray <= next_wgray;
            full <= next_full;
            wq1 <= rgray;
            wq2 <= wq1;
        end
    end

    // storage has no reset, words are gated by the pointers
    always_ff @(posedge wr_clk) begin
        if (wr_en && !full) begin
            mem[wbin[AW-1:0]] <= wr_data;
        end
    end

    // read domain
    always_ff @(posedge rd_clk or negedge rd_rst_n) begin
        if (!rd_rst_n) begin
            rbin <= '0;
            rgray <= '0;
            empty <= 1'h1;
            rq1 <= '0;
            rq2 <= '0;
        end else begin
            rbin <= next_rbin;
            rgray <= next_rgray;
            empty <= next_empty;
            rq1 <= wgray;
            rq2 <= rq1;
        end
    end

    assign rd_data = mem[rbin[AW-1:0]];
endmodule

// two-entry buffer, all outputs registered, stall loses nothing
module tmrx_skid #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // drain side
    input wire logic out_ready,
    output logic out_valid,
    output logic [W-1:0] out_data
);
    logic skid_valid, next_skid_valid, next_out_valid, next_in_ready;
    logic [W-1:0] skid_data, next_skid_data, next_out_data;

    // second slot catches the word accepted while the sink stalls
    always_comb begin
        next_out_valid = out_valid;
        next_out_data = out_data;
        next_skid_valid = skid_valid;
        next_skid_data = skid_data;
        if (out_ready || !out_valid) begin
            if (skid_valid) begin
                next_out_valid = 1'h1;
                next_out_data = skid_data;
                next_skid_valid = 1'h0;
            end else begin
                next_out_valid = in_valid && in_ready;
                next_out_data = in_data;
            end
        end else if (in_valid && in_ready) begin
            next_skid_valid = 1'h1;
            next_skid_data = in_data;
        end
        next_in_ready = !next_skid_valid;
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'h0;
            out_data <= '0;
            skid_valid <= 1'h0;
            skid_data <= '0;
            in_ready <= 1'h0;
        end else begin
            out_valid <= next_out_valid;
            out_data <= next_out_data;
            skid_valid <= next_skid_valid;
            skid_data <= next_skid_data;
            in_ready <= next_in_ready;
        end
    end
endmodule

module tmrx_clock_fabric #(
    parameter int PIXELS_PER_CYCLE = 4,
    parameter bit NATIVE_MODE = 1'b0,
    parameter int FIFO_AW = 4
) (
    // control domain; rst_n clears the whole device
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] htotal,
    output logic ppc_unsupported,
    output logic [tmrx_pkg::AUX_BITS-1:0] aux_data,
    output logic aux_valid,
    // link domain from the phy
    input wire logic link_clk,
    input wire tmrx_pkg::tmrx_link_t link_word,
    input wire logic link_valid,
    output logic link_ready,
    // stream video domain
    input wire logic stream_clk,
    input wire logic stream_rst_n,
    output logic [tmrx_pkg::PIX_BITS-1:0] axis_video_tdata,
    output logic axis_video_tvalid,
    input wire logic axis_video_tready,
    output logic axis_video_tuser,
    output logic axis_video_tlast,
    // native video domain
    input wire logic video_clk,
    output logic [tmrx_pkg::PIX_BITS-1:0] native_pix,
    output logic native_hs,
    output logic native_vs,
    output logic native_de,
    output logic video_rst,
    // audio domain
    input wire logic audio_clk,
    input wire logic audio_rst_n,
    output logic [31:0] axis_audio_tdata,
    output logic [3:0] axis_audio_tid,
    output logic axis_audio_tvalid,
    input wire logic axis_audio_tready
);
    localparam int VW = $bits(tmrx_pkg::tmrx_vid_t);
    localparam int AUW = $bits(tmrx_pkg::tmrx_aud_t);

    logic core_rst_n, link_rst_n, strm_rst_n, aud_rst_n, vid_rst_n, vclk_rst_n, vwr_rst_n, awr_rst_n;
    logic vfull, vempty, vrd, afull, aempty, ard, xfull, xempty, xrd, ppc_bad;
    logic vpush, apush, xpush, held_v, next_held_v, accept;
    tmrx_pkg::tmrx_vid_t held, next_held, vword, vout;
    tmrx_pkg::tmrx_aud_t aout;
    tmrx_pkg::tmrx_frame_t fr, next_fr;
    logic [tmrx_pkg::AUX_BITS-1:0] xout;

    // per-domain reset release; control reset reaches every domain
    tmrx_rst_sync u_rs_core (.clk(core_clk), .arst_n(rst_n), .rst_n_out(core_rst_n));
    tmrx_rst_sync u_rs_link (.clk(link_clk), .arst_n(rst_n), .rst_n_out(link_rst_n));
    tmrx_rst_sync u_rs_strm (.clk(stream_clk), .arst_n(rst_n & stream_rst_n), .rst_n_out(strm_rst_n));
    tmrx_rst_sync u_rs_aud (.clk(audio_clk), .arst_n(rst_n & audio_rst_n), .rst_n_out(aud_rst_n));
    tmrx_rst_sync u_rs_vid (.clk(video_clk), .arst_n(rst_n), .rst_n_out(vid_rst_n));
    // fifo write sides follow their read side's reset, else stale pointers replay old words
    tmrx_rst_sync u_rs_vwr (.clk(link_clk), .arst_n(rst_n & (stream_rst_n | NATIVE_MODE)), .rst_n_out(vwr_rst_n));
    tmrx_rst_sync u_rs_awr (.clk(link_clk), .arst_n(rst_n & audio_rst_n), .rst_n_out(awr_rst_n));

    // video reset for downstream native logic, high while held
    always_ff @(posedge video_clk or negedge rst_n) begin
        if (!rst_n) begin
            video_rst <= 1'h1;
        end else begin
            video_rst <= !vid_rst_n;
        end
    end
    assign vclk_rst_n = vid_rst_n;

    // quad lanes need htotal divisible by four; two-lane builds suit such formats but clock
    // the video side twice as fast, which is harder to close at high resolutions
    assign ppc_bad = (PIXELS_PER_CYCLE == tmrx_pkg::PPC_WIDE) &&
                     ((htotal[1:0] & tmrx_pkg::HTOTAL_QUAD_MASK) != 2'h0);
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            ppc_unsupported <= 1'h0;
        end else begin
            ppc_unsupported <= ppc_bad;
        end
    end

    // link words are taken only while every destination has room
    assign link_ready = !(vfull || afull || xfull) && link_rst_n;
    assign accept = link_valid && link_ready;

    // unpack: one video word is held back so its end-of-line can be seen
    always_comb begin
        next_held = held;
        next_held_v = held_v;
        next_fr = fr;
        vpush = 1'h0;
        apush = 1'h0;
        xpush = 1'h0;
        vword = held;
        if (accept) begin
            unique case (link_word.kind)
                tmrx_pkg::K_VIDEO: begin
                    vpush = held_v;
                    vword.eol = held.de && !link_word.de;
                    next_held.sof = (fr == tmrx_pkg::FR_FIRST) && link_word.de;
                    next_held.eol = 1'h0;
                    next_held.hs = link_word.hs;
                    next_held.vs = link_word.vs;
                    next_held.de = link_word.de;
                    next_held.pix = link_word.payload;
                    next_held_v = 1'h1;
                    unique case (fr)
                        tmrx_pkg::FR_WAIT: next_fr = link_word.vs ? tmrx_pkg::FR_FIRST : fr;
                        tmrx_pkg::FR_FIRST: next_fr = link_word.de ? tmrx_pkg::FR_LINE : fr;
                        tmrx_pkg::FR_LINE: next_fr = link_word.vs ? tmrx_pkg::FR_FIRST : fr;
                        default: next_fr = tmrx_pkg::FR_WAIT;
                    endcase
                end
                tmrx_pkg::K_AUDIO: apush = 1'h1;
                tmrx_pkg::K_AUX: xpush = 1'h1;
                tmrx_pkg::K_NONE: ;
            endcase
        end
    end

    // link domain registers
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            held <= '0;
            held_v <= 1'h0;
            fr <= tmrx_pkg::FR_WAIT;
        end else begin
            held <= next_held;
            held_v <= next_held_v;
            fr <= next_fr;
        end
    end

    // video crossing; read clock follows the build-time output mode
    generate
        if (NATIVE_MODE) begin : g_native
            tmrx_afifo #(.W(VW), .AW(FIFO_AW)) u_vfifo (
                .wr_clk(link_clk), .wr_rst_n(link_rst_n), .wr_en(vpush), .wr_data(vword), .full(vfull),
                .rd_clk(video_clk), .rd_rst_n(vclk_rst_n), .rd_en(vrd), .rd_data(vout), .empty(vempty));
            assign vrd = !vempty;
            // no bridge: every word, blanking included, goes straight out
            always_ff @(posedge video_clk or negedge vclk_rst_n) begin
                if (!vclk_rst_n) begin
                    native_pix <= '0;
                    native_hs <= 1'h0;
                    native_vs <= 1'h0;
                    native_de <= 1'h0;
                end else begin
                    native_pix <= vempty ? native_pix : vout.pix;
                    native_hs <= vempty ? native_hs : vout.hs;
                    native_vs <= vempty ? native_vs : vout.vs;
                    native_de <= !vempty && vout.de;
                end
            end
            assign axis_video_tdata = '0;
            assign axis_video_tvalid = 1'h0;
            assign axis_video_tuser = 1'h0;
            assign axis_video_tlast = 1'h0;
        end else begin : g_stream
            logic sk_ready;
            logic [tmrx_pkg::PIX_BITS+1:0] sk_out;
            tmrx_afifo #(.W(VW), .AW(FIFO_AW)) u_vfifo (
                .wr_clk(link_clk), .wr_rst_n(vwr_rst_n), .wr_en(vpush), .wr_data(vword), .full(vfull),
                .rd_clk(stream_clk), .rd_rst_n(strm_rst_n), .rd_en(vrd), .rd_data(vout), .empty(vempty));
            // blanking words are dropped, active ones wait for the buffer
            assign vrd = !vempty && (!vout.de || sk_ready);
            tmrx_skid #(.W(tmrx_pkg::PIX_BITS + 2)) u_vskid (
                .clk(stream_clk), .rst_n(strm_rst_n), .in_valid(!vempty && vout.de),
                .in_data({vout.sof, vout.eol, vout.pix}), .in_ready(sk_ready),
                .out_ready(axis_video_tready), .out_valid(axis_video_tvalid), .out_data(sk_out));
            assign axis_video_tuser = sk_out[tmrx_pkg::PIX_BITS+1];
            assign axis_video_tlast = sk_out[tmrx_pkg::PIX_BITS];
            assign axis_video_tdata = sk_out[tmrx_pkg::PIX_BITS-1:0];
            assign native_pix = '0;
            assign native_hs = 1'h0;
            assign native_vs = 1'h0;
            assign native_de = 1'h0;
        end
    endgenerate

    // audio crossing into the free-running audio clock
    tmrx_afifo #(.W(AUW), .AW(FIFO_AW)) u_afifo (
        .wr_clk(link_clk), .wr_rst_n(awr_rst_n), .wr_en(apush),
        .wr_data(link_word.payload[tmrx_pkg::AUD_BITS-1:0]), .full(afull),
        .rd_clk(audio_clk), .rd_rst_n(aud_rst_n), .rd_en(ard), .rd_data(aout), .empty(aempty));
    logic a_ready;
    tmrx_skid #(.W(AUW)) u_askid (
        .clk(audio_clk), .rst_n(aud_rst_n), .in_valid(!aempty), .in_data(aout), .in_ready(a_ready),
        .out_ready(axis_audio_tready), .out_valid(axis_audio_tvalid), .out_data({axis_audio_tid, axis_audio_tdata}));
    assign ard = !aempty && a_ready;

    // aux words land in the control domain as one-cycle strobes
    tmrx_afifo #(.W(tmrx_pkg::AUX_BITS), .AW(FIFO_AW)) u_xfifo (
        .wr_clk(link_clk), .wr_rst_n(link_rst_n), .wr_en(xpush),
        .wr_data(link_word.payload[tmrx_pkg::AUX_BITS-1:0]), .full(xfull),
        .rd_clk(core_clk), .rd_rst_n(core_rst_n), .rd_en(xrd), .rd_data(xout), .empty(xempty));
    assign xrd = !xempty;
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            aux_data <= '0;
            aux_valid <= 1'h0;
        end else begin
            aux_data <= xempty ? aux_data : xout;
            aux_valid <= !xempty;
        end
    end
endmodule

// File: rtl/tmrx_pkg.sv
package tmrx_pkg;
    // widest lane set: four pixels, three components, sixteen bits each
    localparam int PIX_BITS = 192;
    localparam int AUD_BITS = 36;
    localparam int AUX_BITS = 32;
    localparam int PPC_WIDE = 4;
    localparam int PPC_NARROW = 2;
    localparam logic [1:0] HTOTAL_QUAD_MASK = 2'h3;
    localparam logic RST_ASSERTED = 1'h0;

    // kind of each parallel word from the phy side
    typedef enum logic [1:0] {
        K_VIDEO = 2'h0,
        K_AUDIO = 2'h1,
        K_AUX = 2'h2,
        K_NONE = 2'h3
    } tmrx_kind_t;

    // frame tracking in the link domain, gray along wait-first-line
    typedef enum logic [1:0] {
        FR_WAIT = 2'h0,
        FR_FIRST = 2'h1,
        FR_LINE = 2'h3
    } tmrx_frame_t;

    typedef struct packed {
        tmrx_kind_t kind;
        logic hs;
        logic vs;
        logic de;
        logic [PIX_BITS-1:0] payload;
    } tmrx_link_t;

    typedef struct packed {
        logic sof;
        logic eol;
        logic hs;
        logic vs;
        logic de;
        logic [PIX_BITS-1:0] pix;
    } tmrx_vid_t;

    typedef struct packed {
        logic [3:0] chan;
        logic [31:0] sample;
    } tmrx_aud_t;
endpackage

// File: testbench/tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    logic core_clk, rst_n, stream_clk, stream_rst_n, audio_clk, audio_rst_n;
    logic link_clk, video_clk, link_valid, link_ready, stall, saw_full;
    logic [15:0] htotal;
    tmrx_pkg::tmrx_link_t link_word;
    logic [tmrx_pkg::PIX_BITS-1:0] vdata, npix;
    logic vvalid, vready, vuser, vlast, nhs, nvs, nde, vrst, ppc_bad, aux_valid, avalid, aready;
    logic [31:0] aux_data, adata;
    logic [3:0] atid;
    logic [193:0] vq[$];
    logic [35:0] aq[$];
    logic [31:0] xq[$];
    int mismatches, tests_run, cycles;
    tmrx_clock_fabric i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .htotal(htotal), .ppc_unsupported(ppc_bad),
        .aux_data(aux_data), .aux_valid(aux_valid), .link_clk(link_clk), .link_word(link_word),
        .link_valid(link_valid), .link_ready(link_ready), .stream_clk(stream_clk), .stream_rst_n(stream_rst_n),
        .axis_video_tdata(vdata), .axis_video_tvalid(vvalid), .axis_video_tready(vready),
        .axis_video_tuser(vuser), .axis_video_tlast(vlast), .video_clk(video_clk), .native_pix(npix),
        .native_hs(nhs), .native_vs(nvs), .native_de(nde), .video_rst(vrst), .audio_clk(audio_clk),
        .audio_rst_n(audio_rst_n), .axis_audio_tdata(adata), .axis_audio_tid(atid),
        .axis_audio_tvalid(avalid), .axis_audio_tready(aready));
    tmrx_phy_model i_phy (.link_clk(link_clk), .video_clk(video_clk), .link_word(link_word),
        .link_valid(link_valid), .link_ready(link_ready));
    // free-running board clocks
    initial begin core_clk = 0; forever #25 core_clk = ~core_clk; end
    initial begin stream_clk = 0; forever #17 stream_clk = ~stream_clk; end
    // audio clock comes from the bench, well above 128 times any sample rate used here
    initial begin audio_clk = 0; forever #23 audio_clk = ~audio_clk; end
    // collectors see only completed handshakes; half-rate drain keeps the skid busy
    always @(posedge stream_clk) begin
        if (vvalid && vready) vq.push_back({vuser, vlast, vdata});
        #2 vready = !stall && !vready;
    end
    always @(posedge audio_clk) if (avalid && aready) aq.push_back({atid, adata});
    always @(posedge link_clk) if (link_valid && !link_ready) saw_full = 1;
    // hang guard
    always @(posedge core_clk) begin
        if (aux_valid) xq.push_back(aux_data);
        cycles++;
        if (cycles == 20000) begin mismatches++; summarize(); end
    end
    function automatic tmrx_pkg::tmrx_link_t mkw(tmrx_pkg::tmrx_kind_t k, logic vs, logic de, logic [191:0] p);
        mkw = '0;
        mkw.kind = k;
        mkw.vs = vs;
        mkw.de = de;
        mkw.payload = p;
    endfunction
    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic ppc_check();
        @(posedge core_clk) #2 htotal = 16'h0672;
        repeat (3) @(posedge core_clk);
        `CHK(ppc_bad, 1'b1)
        #2 htotal = 16'h0898;
        repeat (3) @(posedge core_clk);
        `CHK(ppc_bad, 1'b0)
    endtask
    // receiver stalled for 80 link clocks, link refusal checked, then drained in order
    task automatic video_burst();
        int i;
        stall = 1;
        saw_full = 0;
        vq.delete();
        i_phy.send(mkw(tmrx_pkg::K_VIDEO, 1'b1, 1'b0, '0));
        fork
            for (i = 0; i < 24; i++) i_phy.send(mkw(tmrx_pkg::K_VIDEO, 1'b0, 1'b1, 192'(i + 1)));
            begin
                repeat (80) @(posedge link_clk);
                `CHK(saw_full, 1'b1)
                stall = 0;
            end
        join
        i_phy.send(mkw(tmrx_pkg::K_VIDEO, 1'b0, 1'b0, '0));
        for (i = 0; i < 400 && vq.size() < 24; i++) @(posedge stream_clk);
        `CHK(vq.size(), 24)
        foreach (vq[j]) `CHK(vq[j], {j == 0, j == 23, 192'(j + 1)})
        `CHK(nde, 1'b0)
        `CHK({nhs, nvs, npix}, 194'h0)
    endtask
    task automatic audio_words();
        int i;
        aq.delete();
        for (i = 0; i < 3; i++) i_phy.send(mkw(tmrx_pkg::K_AUDIO, 1'b0, 1'b0, 192'({4'(i + 1), 32'h1234_5670 + 32'(i)})));
        for (i = 0; i < 400 && aq.size() < 3; i++) @(posedge audio_clk);
        `CHK(aq.size(), 3)
        foreach (aq[j]) `CHK(aq[j], {4'(j + 1), 32'h1234_5670 + 32'(j)})
    endtask
    task automatic aux_word();
        int i;
        xq.delete();
        i_phy.send(mkw(tmrx_pkg::K_AUX, 1'b0, 1'b0, 192'(32'hcafe_0001)));
        for (i = 0; i < 100 && xq.size() < 1; i++) @(posedge core_clk);
        `CHK(xq.size(), 1)
        `CHK(aux_data, 32'hcafe_0001)
    endtask
    // per-domain resets, then the control reset clearing everything
    task automatic domain_resets();
        stall = 1;
        i_phy.send(mkw(tmrx_pkg::K_VIDEO, 1'b0, 1'b1, 192'(16'h0077)));
        i_phy.send(mkw(tmrx_pkg::K_VIDEO, 1'b0, 1'b0, '0));
        repeat (20) @(posedge stream_clk);
        `CHK(vvalid, 1'b1)
        #2 stream_rst_n = 0;
        audio_rst_n = 0;
        @(posedge stream_clk);
        #2 `CHK({vvalid, vrst}, 2'h0)
        stream_rst_n = 1;
        audio_rst_n = 1;
        // stalled sink: a replayed stale word would show up as valid here
        repeat (20) @(posedge stream_clk);
        `CHK(vvalid, 1'b0)
        @(posedge core_clk) #2 htotal = 16'h0672;
        repeat (4) @(posedge core_clk);
        #2 rst_n = 0;
        #1 `CHK({ppc_bad, link_ready, vrst}, 3'h1)
        repeat (4) @(posedge core_clk);
        #2 rst_n = 1;
        repeat (10) @(posedge core_clk);
        `CHK({ppc_bad, link_ready, vrst}, 3'h6)
    endtask
    initial begin
        rst_n = 0;
        stream_rst_n = 0;
        audio_rst_n = 0;
        htotal = 16'h0898;
        vready = 0;
        aready = 1;
        stall = 1;
        saw_full = 0;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        repeat (20) @(posedge core_clk);
        #2 rst_n = 1;
        stream_rst_n = 1;
        audio_rst_n = 1;
        repeat (10) @(posedge core_clk);
        ppc_check();
        video_burst();
        audio_words();
        aux_word();
        domain_resets();
        summarize();
    end
endmodule

// File: testbench/tmrx_clock_fabric_assertions.sv
`timescale 1ns/10ps
module tmrx_fabric_checker #(
    parameter int PIXELS_PER_CYCLE = 4,
    parameter bit NATIVE_MODE = 1'b0
) (
    // control and link
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] htotal,
    input wire logic ppc_unsupported,
    input wire logic aux_valid,
    input wire logic link_clk,
    input wire logic link_valid,
    input wire logic link_ready,
    // video
    input wire logic stream_clk,
    input wire logic stream_rst_n,
    input wire logic [tmrx_pkg::PIX_BITS-1:0] axis_video_tdata,
    input wire logic axis_video_tvalid,
    input wire logic axis_video_tready,
    input wire logic axis_video_tuser,
    input wire logic video_clk,
    input wire logic native_de,
    input wire logic video_rst,
    // audio
    input wire logic audio_clk,
    input wire logic audio_rst_n,
    input wire logic [31:0] axis_audio_tdata,
    input wire logic axis_audio_tvalid,
    input wire logic axis_audio_tready
);
    // flag follows htotal one cycle late; first edges after reset skipped
    ppc_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n, 3) |-> ppc_unsupported == (PIXELS_PER_CYCLE == tmrx_pkg::PPC_WIDE && $past(htotal[1:0]) != 2'h0))
        else $error("pixels per cycle flag wrong");
    reset_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> !aux_valid && !ppc_unsupported) else $error("control outputs not cleared");
    // release takes two sync edges, never the raw edge of the input
    video_rst_a: assert property (@(posedge video_clk) disable iff (!rst_n)
        $rose(rst_n) |-> video_rst [*2] ##[1:3] !video_rst) else $error("video reset output timing wrong");
    link_release_a: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(rst_n) |-> !link_ready ##[1:4] link_ready) else $error("link ready on wrong edge");
    native_idle_a: assert property (@(posedge video_clk) disable iff (!rst_n)
        !NATIVE_MODE |-> !native_de) else $error("native output active in stream mode");
    stream_hold_a: assert property (@(posedge stream_clk) disable iff (!rst_n || !stream_rst_n)
        axis_video_tvalid && !axis_video_tready |=> axis_video_tvalid && $stable(axis_video_tdata)
        && $stable(axis_video_tuser)) else $error("stalled video word changed");
    audio_hold_a: assert property (@(posedge audio_clk) disable iff (!rst_n || !audio_rst_n)
        axis_audio_tvalid && !axis_audio_tready |=> axis_audio_tvalid && $stable(axis_audio_tdata))
        else $error("stalled audio word changed");
    stream_reset_a: assert property (@(posedge stream_clk) disable iff (!rst_n)
        !stream_rst_n |=> !axis_video_tvalid) else $error("stream reset ignored");
    audio_reset_a: assert property (@(posedge audio_clk) disable iff (!rst_n)
        !audio_rst_n |=> !axis_audio_tvalid) else $error("audio reset ignored");
    cover property (@(posedge stream_clk) axis_video_tvalid && axis_video_tready && axis_video_tuser);
    cover property (@(posedge audio_clk) axis_audio_tvalid && axis_audio_tready);
    cover property (@(posedge link_clk) link_valid && !link_ready);
endmodule
bind tmrx_clock_fabric tmrx_fabric_checker #(.PIXELS_PER_CYCLE(PIXELS_PER_CYCLE), .NATIVE_MODE(NATIVE_MODE)) i_chk (.*);

// File: testbench/tmrx_phy_model.sv
`timescale 1ns/10ps
module tmrx_phy_model (
    // clocks made by the phy
    output logic link_clk,
    output logic video_clk,
    // parallel link words
    output tmrx_pkg::tmrx_link_t link_word,
    output logic link_valid,
    input wire logic link_ready
);
    // both clocks come from the phy, unrelated in phase to the others
    initial begin link_clk = 0; forever #13 link_clk = ~link_clk; end
    initial begin video_clk = 0; forever #19 video_clk = ~video_clk; end
    initial begin link_valid = 0; link_word = '0; end
    // word held until taken; bounded wait so a stuck ready cannot hang
    task automatic send(input tmrx_pkg::tmrx_link_t w);
        int n;
        n = 0;
        @(posedge link_clk);
        #2 link_word = w;
        link_valid = 1;
        @(posedge link_clk);
        while (!link_ready && n < 2000) begin n++; @(posedge link_clk); end
        #2 link_valid = 0;
        link_word = tmrx_pkg::tmrx_link_t'(~w); // released lines never show the old word
    endtask
endmodule
